// File: design/uart_pin_defines.svh
// Constants for the serial port pin-behaviour block
`ifndef UART_PIN_DEFINES_SVH
`define UART_PIN_DEFINES_SVH

// ==========================================================================
// Line levels
`define UP_MARK      1'b1
`define UP_SPACE     1'b0

// ==========================================================================
// Bit timing: sixteen serial clock periods per bit, eight data bits
`define UP_DIV_W     16
`define UP_DIV_ZERO  16'h0000
`define UP_DIV_ONE   16'h0001
`define UP_OVS_LAST  4'hF
`define UP_OVS_HALF  4'h7
`define UP_OVS_ZERO  4'h0
`define UP_OVS_ONE   4'h1
`define UP_BIT_LAST  3'h7
`define UP_BIT_ZERO  3'h0
`define UP_BIT_ONE   3'h1

// ==========================================================================
// Receive queue geometry and request-to-send thresholds
`define UP_Q_DEPTH   4
`define UP_Q_FULL    3'h4
`define UP_Q_EMPTY   3'h0
`define UP_Q_ONE     3'h1
`define UP_Q_PTR_ONE 2'h1
`define UP_Q_PTR_ZERO 2'h0
`define UP_RTS_STOP  3'h3
`define UP_RTS_GO    3'h1
`define UP_BYTE_ZERO 8'h00

`endif

// File: design/uart_pin_pkg.sv
// Types shared by the serial port pin-behaviour block
package uart_pin_pkg;

    // ======================================================================
    // Frame states, Gray coded along idle-start-data-stop
    typedef enum logic [1:0] {
        FR_IDLE  = 2'h0,
        FR_START = 2'h1,
        FR_DATA  = 2'h3,
        FR_STOP  = 2'h2
    } frame_state_t;

endpackage

// File: design/uart_pin_behaviour.sv
// Serial port channel: line framing, flow control and clock wake-up
`include "uart_pin_defines.svh"

// What this block does
// RULE1: Transmit line sits high when disabled, idle, or in local loopback.
// RULE2: Transmit LSB first, line changes on falling edge of serial clock.
// RULE3: Receiver assembles characters assuming the LSB arrives first.
// RULE4: Any receive line change restarts a serial clock stopped for power-down.
// RULE5: Transmission begins only while the remote party asserts clear-to-send.
// RULE6: Request-to-send is automatic, or optionally follows receive queue fill level.
// RULE7: Each character has one low start bit and at least one high stop bit.
module uart_pin_behaviour
    import uart_pin_pkg::*;
(
    input  wire logic                  I_REF_CLK,
    input  wire logic                  I_RST,
    input  wire logic [`UP_DIV_W-1:0]  I_BAUD_DIV,
    input  wire logic                  I_TX_ENABLE,
    input  wire logic                  I_RX_ENABLE,
    input  wire logic                  I_LOOPBACK,
    input  wire logic                  I_POWER_DOWN,
    input  wire logic                  I_RTS_FROM_QUEUE,
    input  wire logic [7:0]            I_TX_DATA,
    input  wire logic                  I_TX_VALID,
    output logic                       O_TX_READY,
    output logic [7:0]                 O_RX_DATA,
    output logic                       O_RX_VALID,
    input  wire logic                  I_RX_READY,
    output logic                       O_RX_FRAME_ERROR,
    output logic                       O_RX_OVERRUN,
    output logic                       O_CLOCK_RUNNING,
    input  wire logic                  I_SERIAL_RX_IN,
    input  wire logic                  I_CLEAR_TO_SEND_IN_N,
    output logic                       O_SERIAL_TX_OUT,
    output logic                       O_REQUEST_TO_SEND_OUT_N
);

    // ======================================================================
    // Pin synchronisers
    logic rx_meta_q, rx_sync_q, rx_last_q;
    logic cts_meta_q, cts_sync_q;

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            rx_meta_q  <= `UP_MARK;
            rx_sync_q  <= `UP_MARK;
            rx_last_q  <= `UP_MARK;
            cts_meta_q <= 1'b1;
            cts_sync_q <= 1'b1;
        end else begin
            rx_meta_q  <= I_SERIAL_RX_IN;
            rx_sync_q  <= rx_meta_q;
            rx_last_q  <= rx_sync_q;
            cts_meta_q <= I_CLEAR_TO_SEND_IN_N;
            cts_sync_q <= cts_meta_q;
        end
    end

    // ======================================================================
    // Serial clock source and power-down
    logic [`UP_DIV_W-1:0] div_q, div_d;
    logic                 ser_clk_q, stopped_q, stopped_d, pd_last_q;
    wire                  clk_run  = ~stopped_q;
    wire                  div_wrap = clk_run & (div_q == I_BAUD_DIV);
    wire                  fall_evt = div_wrap & ser_clk_q;
    wire                  rise_evt = div_wrap & ~ser_clk_q;
    wire                  rx_edge  = rx_sync_q ^ rx_last_q;
    wire                  pd_rise  = I_POWER_DOWN & ~pd_last_q;

    // Wake beats a coincident stop request so no receive edge is missed
    assign stopped_d = rx_edge ? 1'b0 : (pd_rise ? 1'b1 : stopped_q); // RULE4
    assign div_d     = (~clk_run | div_wrap) ? `UP_DIV_ZERO : div_q + `UP_DIV_ONE;

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            div_q     <= `UP_DIV_ZERO;
            ser_clk_q <= 1'b0;
            stopped_q <= 1'b0;
            pd_last_q <= 1'b0;
        end else begin
            div_q     <= div_d;
            ser_clk_q <= div_wrap ? ~ser_clk_q : ser_clk_q;
            stopped_q <= stopped_d;
            pd_last_q <= I_POWER_DOWN;
        end
    end

    // ======================================================================
    // Transmitter
    frame_state_t tx_st_q, tx_st_d;
    logic [7:0]   tx_sh_q, tx_sh_d;
    logic [3:0]   tx_tick_q, tx_tick_d;
    logic [2:0]   tx_bit_q, tx_bit_d;
    logic         tx_pend_q, tx_pend_d, tx_line_q, tx_line_d, tx_pin_q;
    wire          cts_ok    = ~cts_sync_q;
    wire          tx_accept = I_TX_VALID & O_TX_READY;
    wire          tx_tick_end = tx_tick_q == `UP_OVS_LAST;

    assign O_TX_READY = I_TX_ENABLE & ~tx_pend_q & (tx_st_q == FR_IDLE);

    always_comb begin
        tx_st_d   = tx_st_q;
        tx_sh_d   = tx_sh_q;
        tx_tick_d = tx_tick_q;
        tx_bit_d  = tx_bit_q;
        tx_pend_d = tx_pend_q;
        tx_line_d = tx_line_q;
        case (tx_st_q)
            FR_IDLE: begin
                tx_line_d = `UP_MARK; // RULE1
                if (tx_accept) begin
                    tx_sh_d   = I_TX_DATA;
                    tx_pend_d = 1'b1;
                end
                if (fall_evt & tx_pend_q & cts_ok) begin // RULE5
                    tx_st_d   = FR_START;
                    tx_line_d = `UP_SPACE; // RULE7
                    tx_tick_d = `UP_OVS_ZERO;
                    tx_pend_d = 1'b0;
                end
            end
            FR_START: begin
                if (fall_evt) begin
                    tx_tick_d = tx_tick_q + `UP_OVS_ONE;
                    if (tx_tick_end) begin
                        tx_st_d   = FR_DATA;
                        tx_bit_d  = `UP_BIT_ZERO;
                        tx_line_d = tx_sh_q[0]; // RULE2
                    end
                end
            end
            FR_DATA: begin
                if (fall_evt) begin // RULE2
                    tx_tick_d = tx_tick_q + `UP_OVS_ONE;
                    if (tx_tick_end) begin
                        if (tx_bit_q == `UP_BIT_LAST) begin
                            tx_st_d   = FR_STOP;
                            tx_line_d = `UP_MARK; // RULE7
                        end else begin
                            tx_bit_d  = tx_bit_q + `UP_BIT_ONE;
                            tx_sh_d   = {1'b0, tx_sh_q[7:1]};
                            tx_line_d = tx_sh_q[1];
                        end
                    end
                end
            end
            FR_STOP: begin
                if (fall_evt) begin
                    tx_tick_d = tx_tick_q + `UP_OVS_ONE;
                    if (tx_tick_end) begin
                        tx_st_d = FR_IDLE;
                    end
                end
            end
            default: begin
                tx_st_d   = FR_IDLE;
                tx_line_d = `UP_MARK;
            end
        endcase
        // Disabling aborts a frame at once; the held byte is dropped
        if (~I_TX_ENABLE) begin
            tx_st_d   = FR_IDLE;
            tx_pend_d = 1'b0;
            tx_line_d = `UP_MARK; // RULE1
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            tx_st_q   <= FR_IDLE;
            tx_sh_q   <= `UP_BYTE_ZERO;
            tx_tick_q <= `UP_OVS_ZERO;
            tx_bit_q  <= `UP_BIT_ZERO;
            tx_pend_q <= 1'b0;
            tx_line_q <= `UP_MARK;
            tx_pin_q  <= `UP_MARK;
        end else begin
            tx_st_q   <= tx_st_d;
            tx_sh_q   <= tx_sh_d;
            tx_tick_q <= tx_tick_d;
            tx_bit_q  <= tx_bit_d;
            tx_pend_q <= tx_pend_d;
            tx_line_q <= tx_line_d;
            tx_pin_q  <= I_LOOPBACK ? `UP_MARK : tx_line_d; // RULE1
        end
    end

    assign O_SERIAL_TX_OUT = tx_pin_q;

    // ======================================================================
    // Receiver; loopback feeds it from the internal transmit line
    frame_state_t rx_st_q, rx_st_d;
    logic [7:0]   rx_sh_q, rx_sh_d;
    logic [3:0]   rx_tick_q, rx_tick_d;
    logic [2:0]   rx_bit_q, rx_bit_d;
    logic         rx_push, rx_ferr;
    wire          rx_bit      = I_LOOPBACK ? tx_line_q : rx_sync_q;
    wire          rx_tick_end = rx_tick_q == `UP_OVS_LAST;

    always_comb begin
        rx_st_d   = rx_st_q;
        rx_sh_d   = rx_sh_q;
        rx_tick_d = rx_tick_q;
        rx_bit_d  = rx_bit_q;
        rx_push   = 1'b0;
        rx_ferr   = 1'b0;
        case (rx_st_q)
            FR_IDLE: begin
                if (rise_evt & (rx_bit == `UP_SPACE)) begin
                    rx_st_d   = FR_START;
                    rx_tick_d = `UP_OVS_ZERO;
                end
            end
            FR_START: begin
                // Mid-bit recheck rejects glitches shorter than half a bit
                if (rise_evt) begin
                    rx_tick_d = rx_tick_q + `UP_OVS_ONE;
                    if (rx_tick_q == `UP_OVS_HALF) begin
                        rx_tick_d = `UP_OVS_ZERO;
                        rx_bit_d  = `UP_BIT_ZERO;
                        rx_st_d   = (rx_bit == `UP_SPACE) ? FR_DATA : FR_IDLE; // RULE7
                    end
                end
            end
            FR_DATA: begin
                if (rise_evt) begin
                    rx_tick_d = rx_tick_q + `UP_OVS_ONE;
                    if (rx_tick_end) begin
                        rx_sh_d  = {rx_bit, rx_sh_q[7:1]}; // RULE3
                        rx_bit_d = rx_bit_q + `UP_BIT_ONE;
                        if (rx_bit_q == `UP_BIT_LAST) begin
                            rx_st_d = FR_STOP;
                        end
                    end
                end
            end
            FR_STOP: begin
                if (rise_evt) begin
                    rx_tick_d = rx_tick_q + `UP_OVS_ONE;
                    if (rx_tick_end) begin
                        rx_st_d = FR_IDLE;
                        rx_push = (rx_bit == `UP_MARK); // RULE7
                        rx_ferr = (rx_bit != `UP_MARK);
                    end
                end
            end
            default: begin
                rx_st_d = FR_IDLE;
            end
        endcase
        if (~I_RX_ENABLE) begin
            rx_st_d = FR_IDLE;
            rx_push = 1'b0;
            rx_ferr = 1'b0;
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            rx_st_q   <= FR_IDLE;
            rx_sh_q   <= `UP_BYTE_ZERO;
            rx_tick_q <= `UP_OVS_ZERO;
            rx_bit_q  <= `UP_BIT_ZERO;
        end else begin
            rx_st_q   <= rx_st_d;
            rx_sh_q   <= rx_sh_d;
            rx_tick_q <= rx_tick_d;
            rx_bit_q  <= rx_bit_d;
        end
    end

    // ======================================================================
    // Receive queue; a character arriving while full is dropped
    logic [7:0] q_mem_q [`UP_Q_DEPTH];
    logic [1:0] q_wr_q, q_rd_q;
    logic [2:0] q_cnt_q;
    logic       ferr_q, ovr_q, rts_fifo_q, rts_n_q;
    wire        q_full = q_cnt_q == `UP_Q_FULL;
    wire        q_wr   = rx_push & ~q_full;
    wire        q_rd   = I_RX_READY & O_RX_VALID;

    assign O_RX_VALID = q_cnt_q != `UP_Q_EMPTY;
    assign O_RX_DATA  = q_mem_q[q_rd_q];

    generate
        for (genvar g = 0; g < `UP_Q_DEPTH; g++) begin : g_q
            always_ff @(posedge I_REF_CLK or posedge I_RST) begin
                if (I_RST) begin
                    q_mem_q[g] <= `UP_BYTE_ZERO;
                end else if (q_wr && q_wr_q == 2'(g)) begin
                    q_mem_q[g] <= rx_sh_q;
                end
            end
        end
    endgenerate

    // ======================================================================
    // Request-to-send: auto asks while a character waits or is on the line
    wire rts_auto = tx_pend_q | (tx_st_q != FR_IDLE); // RULE6
    wire rts_want = I_RTS_FROM_QUEUE ? rts_fifo_q : rts_auto; // RULE6

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            q_wr_q     <= `UP_Q_PTR_ZERO;
            q_rd_q     <= `UP_Q_PTR_ZERO;
            q_cnt_q    <= `UP_Q_EMPTY;
            ferr_q     <= 1'b0;
            ovr_q      <= 1'b0;
            rts_fifo_q <= 1'b1;
            rts_n_q    <= 1'b1;
        end else begin
            q_wr_q  <= q_wr ? q_wr_q + `UP_Q_PTR_ONE : q_wr_q;
            q_rd_q  <= q_rd ? q_rd_q + `UP_Q_PTR_ONE : q_rd_q;
            q_cnt_q <= q_cnt_q + (q_wr ? `UP_Q_ONE : `UP_Q_EMPTY)
                               - (q_rd ? `UP_Q_ONE : `UP_Q_EMPTY);
            ferr_q  <= rx_ferr;
            ovr_q   <= rx_push & q_full;
            // Hysteresis keeps the line from chattering around one level
            if (q_cnt_q >= `UP_RTS_STOP) begin
                rts_fifo_q <= 1'b0; // RULE6
            end else if (q_cnt_q <= `UP_RTS_GO) begin
                rts_fifo_q <= 1'b1; // RULE6
            end
            rts_n_q <= ~rts_want;
        end
    end

    assign O_RX_FRAME_ERROR        = ferr_q;
    assign O_RX_OVERRUN            = ovr_q;
    assign O_REQUEST_TO_SEND_OUT_N = rts_n_q;
    assign O_CLOCK_RUNNING         = clk_run;

endmodule

// File: sim/uart_pin_behaviour_props.sv
// Pin-level assertions for the serial channel
module uart_pin_behaviour_props (
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    input wire logic I_TX_ENABLE,
    input wire logic I_LOOPBACK,
    input wire logic I_POWER_DOWN,
    input wire logic I_RTS_FROM_QUEUE,
    input wire logic I_TX_VALID,
    input wire logic O_TX_READY,
    input wire logic O_RX_VALID,
    input wire logic O_RX_FRAME_ERROR,
    input wire logic O_RX_OVERRUN,
    input wire logic O_CLOCK_RUNNING,
    input wire logic I_SERIAL_RX_IN,
    input wire logic I_CLEAR_TO_SEND_IN_N,
    input wire logic O_SERIAL_TX_OUT,
    input wire logic O_REQUEST_TO_SEND_OUT_N
);
    timeunit 1ns;
    timeprecision 100ps;
    // ======================================================================
    // Helpers: a byte accepted and not yet started, and recent receive pin
    logic       armed_q;
    logic [3:0] rx_hist_q;
    wire        rx_calm = (rx_hist_q == {4{I_SERIAL_RX_IN}});
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            armed_q   <= 1'b0;
            rx_hist_q <= 4'hF;
        end else begin
            armed_q   <= I_TX_ENABLE & ((I_TX_VALID & O_TX_READY) | (armed_q & O_SERIAL_TX_OUT));
            rx_hist_q <= {rx_hist_q[2:0], I_SERIAL_RX_IN};
        end
    end
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_RST);
    a_mark_disabled: assert property (!I_TX_ENABLE [*2] |-> O_SERIAL_TX_OUT)
        else $error("transmit line not at mark while disabled");
    a_mark_loopback: assert property (I_LOOPBACK [*2] |-> O_SERIAL_TX_OUT)
        else $error("transmit line not at mark in loopback");
    a_mark_idle: assert property (O_TX_READY |-> O_SERIAL_TX_OUT && I_TX_ENABLE)
        else $error("idle transmitter not at mark");
    a_start_needs_cts: assert property ($fell(O_SERIAL_TX_OUT) && armed_q
        |-> !$past(I_CLEAR_TO_SEND_IN_N, 3))
        else $error("start bit sent without clear-to-send");
    a_start_bit_low: assert property ($fell(O_SERIAL_TX_OUT) && armed_q
        |-> !O_SERIAL_TX_OUT [*8])
        else $error("start bit too short");
    a_rts_auto_req: assert property (!I_RTS_FROM_QUEUE && I_TX_VALID && O_TX_READY
        |-> ##[1:3] !O_REQUEST_TO_SEND_OUT_N)
        else $error("request-to-send not raised for held byte");
    a_overrun_when_full: assert property (O_RX_OVERRUN |-> O_RX_VALID)
        else $error("overrun with empty receive queue");
    a_frame_err_pulse: assert property (O_RX_FRAME_ERROR |=> !O_RX_FRAME_ERROR)
        else $error("frame error longer than one cycle");
    a_clock_stop: assert property ($rose(I_POWER_DOWN) && rx_calm
        |-> ##[1:2] !O_CLOCK_RUNNING)
        else $error("serial clock did not stop");
    a_wake_on_rx: assert property (!O_CLOCK_RUNNING && $changed(I_SERIAL_RX_IN)
        |-> ##[1:4] O_CLOCK_RUNNING)
        else $error("receive activity did not restart clock");
    c_start: cover property ($fell(O_SERIAL_TX_OUT) && armed_q);
    c_overrun: cover property (O_RX_OVERRUN);
    c_wake: cover property ($rose(O_CLOCK_RUNNING));
endmodule

bind uart_pin_behaviour uart_pin_behaviour_props u_props (
    .I_REF_CLK, .I_RST, .I_TX_ENABLE, .I_LOOPBACK, .I_POWER_DOWN, .I_RTS_FROM_QUEUE,
    .I_TX_VALID, .O_TX_READY, .O_RX_VALID, .O_RX_FRAME_ERROR, .O_RX_OVERRUN,
    .O_CLOCK_RUNNING, .I_SERIAL_RX_IN, .I_CLEAR_TO_SEND_IN_N, .O_SERIAL_TX_OUT,
    .O_REQUEST_TO_SEND_OUT_N
);

// File: sim/uart_remote_peer.sv
// Remote serial device: drives receive pin and clear-to-send, decodes transmit pin
module uart_remote_peer #(
    parameter int BIT_CYC = 32
) (
    input  wire logic clk,
    input  wire logic line_in,
    output logic      line_out,
    output logic      cts_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] got_q[$];
    logic       stop_q[$];
    logic [7:0] rx_byte;
    initial begin
        line_out = 1'b1;
        cts_n    = 1'b1;
    end
    task automatic set_cts(input logic v);
        cts_n = v;
    endtask
    // ======================================================================
    // One frame, start bit first then data LSB first; a low stop is a fault
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        f = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_out = f[i];
            repeat (BIT_CYC) @(posedge clk);
            #1;
        end
        line_out = 1'b1;
    endtask
    // Sample mid-bit, LSB first
    always begin
        @(negedge line_in);
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            rx_byte[i] = line_in;
        end
        repeat (BIT_CYC) @(posedge clk);
        got_q.push_back(rx_byte);
        stop_q.push_back(line_in);
    end
endmodule

// File: sim/uart_pin_behaviour_bench.sv
// Self-checking bench for the serial channel pin behaviour
`include "uart_pin_defines.svh"
module uart_pin_behaviour_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk, rst, tx_en, rx_en, loop_en, pwr_dn, rts_mode, tx_valid, rx_ready;
    logic [7:0] tx_data, rx_data;
    logic       tx_ready, rx_valid, ferr, ovr, clk_run, rx_pin, cts_n, tx_pin, rts_n;
    logic       ferr_seen, ovr_seen;
    int         err_total, checked, cycles, lows;
    uart_pin_behaviour u_dut (
        .I_REF_CLK(clk), .I_RST(rst), .I_BAUD_DIV(`UP_DIV_ZERO), .I_TX_ENABLE(tx_en),
        .I_RX_ENABLE(rx_en), .I_LOOPBACK(loop_en), .I_POWER_DOWN(pwr_dn),
        .I_RTS_FROM_QUEUE(rts_mode), .I_TX_DATA(tx_data), .I_TX_VALID(tx_valid),
        .O_TX_READY(tx_ready), .O_RX_DATA(rx_data), .O_RX_VALID(rx_valid),
        .I_RX_READY(rx_ready), .O_RX_FRAME_ERROR(ferr), .O_RX_OVERRUN(ovr),
        .O_CLOCK_RUNNING(clk_run), .I_SERIAL_RX_IN(rx_pin), .I_CLEAR_TO_SEND_IN_N(cts_n),
        .O_SERIAL_TX_OUT(tx_pin), .O_REQUEST_TO_SEND_OUT_N(rts_n));
    // Divider 0 gives 32 reference cycles per bit
    uart_remote_peer #(.BIT_CYC(32)) u_peer (
        .clk(clk), .line_in(tx_pin), .line_out(rx_pin), .cts_n(cts_n));
    // ======================================================================
    // Shared tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic offer(input logic [7:0] b);
        tx_data  = b;
        tx_valid = 1'b1;
        for (int n = 0; n < 2000 && tx_ready !== 1'b1; n++) step(1);
        step(1);
        tx_valid = 1'b0;
    endtask
    task automatic pop(input logic [7:0] exp);
        for (int n = 0; n < 400 && rx_valid !== 1'b1; n++) step(1);
        chk(rx_data, exp);
        rx_ready = 1'b1;
        step(1);
        rx_ready = 1'b0;
        step(1);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ======================================================================
    // Scenarios
    task automatic t_tx();
        chk(8'({tx_pin, rts_n, rx_valid, clk_run}), 8'h0D);
        offer(8'h35);
        step(3);
        chk(8'(rts_n), 8'h00);
        step(200);
        chk(8'(tx_pin), 8'h01);
        u_peer.set_cts(1'b0);
        offer(8'hCA);
        step(360);
        chk(u_peer.got_q[0], 8'h35);
        chk(u_peer.got_q[1], 8'hCA);
        chk(8'({u_peer.stop_q[0], u_peer.stop_q[1]}), 8'h03);
        chk(8'(rts_n), 8'h01);
        $display("test tx done");
    endtask
    task automatic t_loop();
        loop_en = 1'b1;
        step(2);
        offer(8'h96);
        lows = 0;
        for (int i = 0; i < 400; i++) begin
            if (tx_pin !== 1'b1) lows++;
            step(1);
        end
        chk(8'(lows), 8'h00);
        pop(8'h96);
        loop_en = 1'b0;
        tx_en   = 1'b0;
        step(2);
        chk(8'({tx_ready, tx_pin}), 8'h01);
        tx_en = 1'b1;
        $display("test loopback done");
    endtask
    task automatic t_rx();
        u_peer.send(8'h2D, 1'b1);
        pop(8'h2D);
        u_peer.send(8'h71, 1'b0);
        step(4);
        chk(8'({ferr_seen, rx_valid}), 8'h02);
        rx_en = 1'b0;
        u_peer.send(8'h3C, 1'b1);
        step(4);
        chk(8'(rx_valid), 8'h00);
        rx_en = 1'b1;
        $display("test rx done");
    endtask
    task automatic t_queue();
        rts_mode = 1'b1;
        for (int i = 0; i < 5; i++) begin
            u_peer.send(8'(8'h11 * (i + 1)), 1'b1);
            step(4);
            if (i == 0) chk(8'(rts_n), 8'h00);
            if (i == 2) chk(8'(rts_n), 8'h01);
        end
        chk(8'(ovr_seen), 8'h01);
        for (int i = 0; i < 3; i++) pop(8'(8'h11 * (i + 1)));
        step(4);
        chk(8'(rts_n), 8'h00);
        pop(8'h44);
        rts_mode = 1'b0;
        $display("test queue done");
    endtask
    task automatic t_power();
        pwr_dn = 1'b1;
        step(3);
        chk(8'(clk_run), 8'h00);
        u_peer.send(8'h5A, 1'b1);
        chk(8'(clk_run), 8'h01);
        pop(8'h5A);
        pwr_dn = 1'b0;
        $display("test power done");
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Sticky pulse flags and hang limit
    always @(posedge clk) begin
        if (ferr === 1'b1) ferr_seen = 1'b1;
        if (ovr === 1'b1) ovr_seen = 1'b1;
        cycles++;
        if (cycles == 12000) begin
            err_total++;
            stop_test();
        end
    end
    initial begin
        {rst, tx_en, rx_en} = 3'h7;
        {loop_en, pwr_dn, rts_mode, tx_valid, rx_ready, ferr_seen, ovr_seen} = 7'h00;
        tx_data   = 8'h00;
        err_total = 0;
        checked   = 0;
        cycles    = 0;
        step(10);
        rst = 1'b0;
        step(1);
        t_tx();
        t_loop();
        t_rx();
        t_queue();
        t_power();
        stop_test();
    end
endmodule
